// ===== mpc_pkg.sv
// Constants for the master page power and reference register group.
// Assumes a 24-bit serial frame: read flag, three spare bits, 12-bit
// address, 8-bit data, most significant bit first.
package mpc_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS   = 24;
  localparam int          HEAD_BITS    = 16;
  localparam logic [4:0]  HEAD_CNT     = 5'h10;
  localparam logic [4:0]  FRAME_CNT    = 5'h18;
  localparam int          RW_POS       = 15;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] SOFT_RESET_ADDR      = 12'h000;
  localparam logic [11:0] CONVERTER_PAGE_ADDR  = 12'h011;
  localparam logic [11:0] MASTER_PAGE_ADDR     = 12'h012;
  localparam logic [11:0] POWER_DOWN_CONTROL   = 12'h020;
  localparam logic [11:0] BIAS_IMPEDANCE_SEL   = 12'h032;
  localparam logic [11:0] CHB_GATE_AND_TERM    = 12'h039;
  localparam logic [11:0] REF_DELAY_CONTROL    = 12'h03c;
  localparam logic [11:0] REF_DELAY_LOW        = 12'h05a;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SOFT_RESET_HI_POS      = 7;
  localparam int SOFT_RESET_LO_POS      = 0;
  localparam int MASTER_PAGE_POS        = 2;
  localparam int REF_CAPTURE_OFF_POS    = 4;
  localparam int SECOND_CH_OFF_POS      = 1;
  localparam int WHOLE_DEVICE_OFF_POS   = 0;
  localparam int BIAS_HIGH_IMP_POS      = 5;
  localparam int SECOND_CH_GATE_POS     = 1;
  localparam int SYNC_TERM_OFF_POS      = 0;
  localparam int REF_DELAY_ON_POS       = 6;
  localparam int REF_DELAY_HIGH_LSB     = 0;
  localparam int REF_DELAY_LOW_LSB      = 5;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONVERTER_PAGE_RESET = 8'h00;
  localparam logic [1:0] REF_DELAY_HIGH_RESET = 2'h0;
  localparam logic [2:0] REF_DELAY_LOW_RESET  = 3'h0;

  // ----------------------------------------------------------------
  // Reference delay table, in picoseconds
  // ----------------------------------------------------------------
  localparam logic [4:0] DELAY_FIRST_CODE = 5'h08;
  localparam logic [4:0] DELAY_LAST_CODE  = 5'h03;
  localparam logic [8:0] DELAY_FIRST_PS   = 9'h0af;
  localparam logic [8:0] DELAY_STEP_PS    = 9'h019;

endpackage : mpc_pkg

// ===== mpc_master_page.sv
// Master page power-down, bias, termination and reference delay block.
// Assumes serial pins synchronous to clock and sclk well below clock/4.
`timescale 1ns/100ps

module mpc_master_page (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        resetn,
  // Serial configuration port
  input  wire logic        sclk,
  input  wire logic        sen_n,
  input  wire logic        sdin,
  output logic             sdout,
  output logic             sdout_oe,
  // Reference pulse path
  input  wire logic        ref_pulse_in,
  output logic             ref_pulse_out,
  // Analog controls
  output logic             reference_capture_off,
  output logic             second_channel_off,
  output logic             whole_device_off,
  output logic             bias_high_impedance,
  output logic             sync_termination_off,
  output logic             reference_delay_on,
  output logic [4:0]       reference_delay_code,
  output logic [8:0]       reference_delay_ps
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sclk_prev;
    logic [4:0]  count;
    logic [23:0] shift;
    logic [7:0]  rd_shift;
    logic        rd_active;
    logic        sdout;
    logic        sdout_oe;
    logic [7:0]  converter_page;
    logic        master_page;
    logic        capture_off;
    logic        ch_off;
    logic        dev_off;
    logic        bias_hi;
    logic        ch_gate;
    logic        term_off;
    logic        delay_on;
    logic [1:0]  delay_high;
    logic [2:0]  delay_low;
    logic        pulse_out;
    logic        o_capture_off;
    logic        o_ch_off;
    logic        o_dev_off;
    logic        o_bias_hi;
    logic        o_term_off;
    logic        o_delay_on;
    logic [4:0]  o_code;
    logic [8:0]  o_ps;
  } mpc_state_t;

  mpc_state_t s;
  mpc_state_t next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Codes outside the table give no delay rather than a guess
  function automatic logic [8:0] mpc_delay_ps(input logic [4:0] code);
    logic [8:0] steps;
    steps = 9'({4'h0, mpc_pkg::DELAY_FIRST_CODE} - {4'h0, code});
    if (code <= mpc_pkg::DELAY_FIRST_CODE &&
        code >= mpc_pkg::DELAY_LAST_CODE) begin
      mpc_delay_ps = mpc_pkg::DELAY_FIRST_PS +
                     9'(steps * mpc_pkg::DELAY_STEP_PS);
    end else begin
      mpc_delay_ps = 9'h000;
    end
  endfunction : mpc_delay_ps

  // Master page registers answer only while that page is selected
  function automatic logic mpc_page_ok(input mpc_state_t st);
    mpc_page_ok = st.master_page &&
                  st.converter_page == mpc_pkg::CONVERTER_PAGE_RESET;
  endfunction : mpc_page_ok

  function automatic logic [7:0] mpc_read(input mpc_state_t st,
                                          input logic [11:0] addr);
    mpc_read = 8'h00;
    if (addr == mpc_pkg::CONVERTER_PAGE_ADDR) begin
      mpc_read = st.converter_page;
    end else if (addr == mpc_pkg::MASTER_PAGE_ADDR) begin
      mpc_read[mpc_pkg::MASTER_PAGE_POS] = st.master_page;
    end else if (!mpc_page_ok(st)) begin
      mpc_read = 8'h00;
    end else if (addr == mpc_pkg::POWER_DOWN_CONTROL) begin
      mpc_read[mpc_pkg::REF_CAPTURE_OFF_POS]  = st.capture_off;
      mpc_read[mpc_pkg::SECOND_CH_OFF_POS]    = st.ch_off;
      mpc_read[mpc_pkg::WHOLE_DEVICE_OFF_POS] = st.dev_off;
    end else if (addr == mpc_pkg::BIAS_IMPEDANCE_SEL) begin
      mpc_read[mpc_pkg::BIAS_HIGH_IMP_POS] = st.bias_hi;
    end else if (addr == mpc_pkg::CHB_GATE_AND_TERM) begin
      mpc_read[mpc_pkg::SECOND_CH_GATE_POS] = st.ch_gate;
      mpc_read[mpc_pkg::SYNC_TERM_OFF_POS]  = st.term_off;
    end else if (addr == mpc_pkg::REF_DELAY_CONTROL) begin
      mpc_read[mpc_pkg::REF_DELAY_ON_POS] = st.delay_on;
      mpc_read[mpc_pkg::REF_DELAY_HIGH_LSB +: 2] = st.delay_high;
    end else if (addr == mpc_pkg::REF_DELAY_LOW) begin
      mpc_read[mpc_pkg::REF_DELAY_LOW_LSB +: 3] = st.delay_low;
    end
  endfunction : mpc_read

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        rise;
    logic        fall;
    logic [23:0] word;
    logic [11:0] addr;
    logic [7:0]  data;
    rise = 1'b0;
    fall = 1'b0;
    word = 24'h000000;
    addr = 12'h000;
    data = 8'h00;
    next_s = s;
    next_s.sclk_prev = sclk;
    rise = sclk && !s.sclk_prev;
    fall = !sclk && s.sclk_prev;
    word = {s.shift[22:0], sdin};
    if (sen_n) begin
      // Aborted frames are dropped whole, nothing half-written
      next_s.count     = 5'h00;
      next_s.rd_active = 1'b0;
      next_s.sdout_oe  = 1'b0;
      next_s.sdout     = 1'b0;
    end else if (rise && s.count < mpc_pkg::FRAME_CNT) begin
      next_s.shift = word;
      next_s.count = s.count + 5'h01;
      if (s.count + 5'h01 == mpc_pkg::HEAD_CNT) begin
        addr = word[11:0];
        next_s.rd_shift  = mpc_read(s, addr);
        next_s.rd_active = word[mpc_pkg::RW_POS];
      end
      if (s.count + 5'h01 == mpc_pkg::FRAME_CNT && !s.rd_active) begin
        addr = word[19:8];
        data = word[7:0];
        if (addr == mpc_pkg::SOFT_RESET_ADDR) begin
          if (data[mpc_pkg::SOFT_RESET_HI_POS] &&
              data[mpc_pkg::SOFT_RESET_LO_POS]) begin
            next_s.converter_page = mpc_pkg::CONVERTER_PAGE_RESET;
            next_s.master_page = 1'b0;
            next_s.capture_off = 1'b0;
            next_s.ch_off      = 1'b0;
            next_s.dev_off     = 1'b0;
            next_s.bias_hi     = 1'b0;
            next_s.ch_gate     = 1'b0;
            next_s.term_off    = 1'b0;
            next_s.delay_on    = 1'b0;
            next_s.delay_high  = mpc_pkg::REF_DELAY_HIGH_RESET;
            next_s.delay_low   = mpc_pkg::REF_DELAY_LOW_RESET;
          end
        end else if (addr == mpc_pkg::CONVERTER_PAGE_ADDR) begin
          next_s.converter_page = data;
        end else if (addr == mpc_pkg::MASTER_PAGE_ADDR) begin
          next_s.master_page = data[mpc_pkg::MASTER_PAGE_POS];
        end else if (!mpc_page_ok(s)) begin
          next_s.master_page = s.master_page;
        end else if (addr == mpc_pkg::POWER_DOWN_CONTROL) begin
          next_s.capture_off = data[mpc_pkg::REF_CAPTURE_OFF_POS];
          next_s.ch_off      = data[mpc_pkg::SECOND_CH_OFF_POS];
          next_s.dev_off     = data[mpc_pkg::WHOLE_DEVICE_OFF_POS];
        end else if (addr == mpc_pkg::BIAS_IMPEDANCE_SEL) begin
          next_s.bias_hi = data[mpc_pkg::BIAS_HIGH_IMP_POS];
        end else if (addr == mpc_pkg::CHB_GATE_AND_TERM) begin
          // Bits 6 and 4 carry no state here
          next_s.ch_gate  = data[mpc_pkg::SECOND_CH_GATE_POS];
          next_s.term_off = data[mpc_pkg::SYNC_TERM_OFF_POS];
        end else if (addr == mpc_pkg::REF_DELAY_CONTROL) begin
          next_s.delay_on   = data[mpc_pkg::REF_DELAY_ON_POS];
          next_s.delay_high = data[mpc_pkg::REF_DELAY_HIGH_LSB +: 2];
        end else if (addr == mpc_pkg::REF_DELAY_LOW) begin
          next_s.delay_low = data[mpc_pkg::REF_DELAY_LOW_LSB +: 3];
        end
      end
    end else if (fall && s.rd_active && s.count >= mpc_pkg::HEAD_CNT &&
                 s.count < mpc_pkg::FRAME_CNT) begin
      next_s.sdout    = s.rd_shift[7];
      next_s.sdout_oe = 1'b1;
      next_s.rd_shift = {s.rd_shift[6:0], 1'b0};
    end else if (fall && s.count >= mpc_pkg::FRAME_CNT) begin
      next_s.sdout_oe = 1'b0;
    end

    // Outputs follow the stored fields one cycle later
    next_s.o_capture_off = s.capture_off;
    next_s.pulse_out     = ref_pulse_in && !s.capture_off;
    next_s.o_ch_off      = s.ch_off && s.ch_gate;
    next_s.o_dev_off     = s.dev_off;
    next_s.o_bias_hi     = s.bias_hi;
    next_s.o_term_off    = s.term_off;
    next_s.o_delay_on    = s.delay_on;
    next_s.o_code        = {s.delay_high, s.delay_low};
    next_s.o_ps          = s.delay_on ?
                           mpc_delay_ps({s.delay_high, s.delay_low}) :
                           9'h000;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sdout                 = s.sdout;
  assign sdout_oe              = s.sdout_oe;
  assign ref_pulse_out         = s.pulse_out;
  assign reference_capture_off = s.o_capture_off;
  assign second_channel_off    = s.o_ch_off;
  assign whole_device_off      = s.o_dev_off;
  assign bias_high_impedance   = s.o_bias_hi;
  assign sync_termination_off  = s.o_term_off;
  assign reference_delay_on    = s.o_delay_on;
  assign reference_delay_code  = s.o_code;
  assign reference_delay_ps    = s.o_ps;

endmodule : mpc_master_page

// ===== mpc_host_model.sv
// Serial host model for the four-wire configuration port.
// Assumes the bench clock; every serial phase lasts three clocks.
`timescale 1ns/100ps

module mpc_host_model (
  // Clock
  input  wire logic clock,
  // Serial port
  output logic      sclk,
  output logic      sen_n,
  output logic      sdin,
  input  wire logic sdout
);
  initial begin
    sclk  = 1'b0;
    sen_n = 1'b1;
    sdin  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_clk

  // Read bits taken just before each rise, where sdout has settled
  task automatic xfer(input logic rw, input logic [11:0] addr,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    logic [23:0] word;
    word  = {rw, 3'h0, addr, wdata};
    rdata = 8'h00;
    wait_clk(1);
    sen_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdin = word[i];
      wait_clk(3);
      if (i < 8) rdata[i] = sdout;
      sclk = 1'b1;
      wait_clk(3);
      sclk = 1'b0;
    end
    wait_clk(3);
    sen_n = 1'b1;
    // Released line must not keep a plausible stale bit
    sdin  = ~sdin;
    wait_clk(3);
  endtask : xfer
endmodule : mpc_host_model

// ===== mpc_master_page_properties.sv
// Port checks for the master page block.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/100ps

module mpc_master_page_checker (
  // Clock and reset
  input wire logic       clock,
  input wire logic       resetn,
  // Serial port
  input wire logic       sen_n,
  input wire logic       sdout_oe,
  // Reference path
  input wire logic       ref_pulse_in,
  input wire logic       ref_pulse_out,
  // Controls
  input wire logic       reference_capture_off,
  input wire logic       second_channel_off,
  input wire logic       whole_device_off,
  input wire logic       bias_high_impedance,
  input wire logic       sync_termination_off,
  input wire logic       reference_delay_on,
  input wire logic [4:0] reference_delay_code,
  input wire logic [8:0] reference_delay_ps
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  wire logic [5:0] ctl = {reference_capture_off, second_channel_off,
    whole_device_off, bias_high_impedance, sync_termination_off,
    reference_delay_on};
  wire logic       in_table = reference_delay_code >= 5'h03 &&
                              reference_delay_code <= 5'h08;

  // Three samples cover a field-to-output lag of up to two clocks
  sequence s_cap_held; reference_capture_off [*3]; endsequence
  sequence s_cap_open; !reference_capture_off [*3]; endsequence
  sequence s_idle; sen_n [*4]; endsequence

  property p_reset_zero;
    $rose(resetn) |-> ctl == 6'h00 && reference_delay_ps == 9'h000;
  endproperty
  property p_cap_block; s_cap_held |-> !$past(ref_pulse_out); endproperty
  property p_cap_pass;
    s_cap_open |-> $past(ref_pulse_out) == $past(ref_pulse_in, 2);
  endproperty
  property p_idle_stable; s_idle |=> $stable(ctl); endproperty
  property p_delay_table;
    reference_delay_on && in_table && $stable(reference_delay_code) |->
      reference_delay_ps == 9'(175 + 25 * (8 - int'(reference_delay_code)));
  endproperty
  property p_delay_zero;
    (!reference_delay_on || !in_table) &&
      $stable({reference_delay_on, reference_delay_code}) |->
      reference_delay_ps == 9'h000;
  endproperty
  property p_oe_idle; sen_n [*3] |-> !sdout_oe; endproperty
  property p_oe_start;
    $rose(sdout_oe) |-> !sen_n && !$past(sen_n, 50);
  endproperty

  a_reset_zero:  assert property (p_reset_zero)
    else $error("bad reset");
  a_cap_block:   assert property (p_cap_block)
    else $error("pulse leak");
  a_cap_pass:    assert property (p_cap_pass)
    else $error("pulse lost");
  a_idle_stable: assert property (p_idle_stable)
    else $error("idle change");
  a_delay_table: assert property (p_delay_table)
    else $error("bad delay");
  a_delay_zero:  assert property (p_delay_zero)
    else $error("stray delay");
  a_oe_idle:     assert property (p_oe_idle)
    else $error("oe idle");
  a_oe_start:    assert property (p_oe_start)
    else $error("oe early");
endmodule : mpc_master_page_checker

bind mpc_master_page mpc_master_page_checker u_chk (.clock, .resetn,
  .sen_n, .sdout_oe, .ref_pulse_in, .ref_pulse_out, .reference_capture_off,
  .second_channel_off, .whole_device_off, .bias_high_impedance,
  .sync_termination_off, .reference_delay_on, .reference_delay_code,
  .reference_delay_ps);

// ===== test_master_page_power_sysref_config.sv
// Self-checking bench for the master page block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); \
  end \
end

module test_master_page_power_sysref_config;
  logic       clock, resetn, ref_pulse_in, sclk, sen_n, sdin;
  logic       sdout, sdout_oe, ref_pulse_out, reference_capture_off;
  logic       second_channel_off, whole_device_off, bias_high_impedance;
  logic       sync_termination_off, reference_delay_on;
  logic [4:0] reference_delay_code;
  logic [8:0] reference_delay_ps;
  logic [7:0] rd;
  logic [8:0] exp_ps;
  int         fail_count, n_compared, cycles;
  int         oe_cycles, oe_base;
  wire logic [6:0] flags = {reference_capture_off, second_channel_off,
    whole_device_off, bias_high_impedance, sync_termination_off,
    reference_delay_on, ref_pulse_out};

  mpc_master_page u_dut (.clock, .resetn, .sclk, .sen_n, .sdin, .sdout,
    .sdout_oe, .ref_pulse_in, .ref_pulse_out, .reference_capture_off,
    .second_channel_off, .whole_device_off, .bias_high_impedance,
    .sync_termination_off, .reference_delay_on, .reference_delay_code,
    .reference_delay_ps);
  mpc_host_model u_host (.clock, .sclk, .sen_n, .sdin, .sdout);

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, rd);
  endtask : wr
  // Read drive lasts eight serial bits of six clocks each
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    oe_base = oe_cycles;
    u_host.xfer(1'b1, a, 8'h00, rd);
    `CHK("read data", e, rd)
    `CHK("oe cycles", 48, oe_cycles - oe_base)
    `CHK("oe", 1'b0, sdout_oe)
  endtask : rd_chk
  task automatic pulse(input logic e);
    ref_pulse_in = 1'b1;
    @(posedge clock);
    #1 ref_pulse_in = 1'b0;
    `CHK("pulse out", e, ref_pulse_out)
  endtask : pulse
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    if (sdout_oe) oe_cycles++;
  end
  // Whole run needs about 5600 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    ref_pulse_in = 1'b0;
    repeat (4) @(posedge clock);
    #1 resetn = 1'b1;
    `CHK("flags", 7'h00, flags)
    wr(12'h020, 8'h01);
    `CHK("flags", 7'h00, flags)
    wr(12'h012, 8'h04);
    rd_chk(12'h012, 8'h04);
    wr(12'h020, 8'h13);
    `CHK("flags", 7'h50, flags)
    rd_chk(12'h020, 8'h13);
    pulse(1'b0);
    wr(12'h039, 8'h53);
    `CHK("flags", 7'h74, flags)
    rd_chk(12'h039, 8'h03);
    wr(12'h020, 8'h02);
    `CHK("flags", 7'h24, flags)
    pulse(1'b1);
    wr(12'h039, 8'h50);
    `CHK("flags", 7'h00, flags)
    wr(12'h032, 8'h20);
    `CHK("flags", 7'h08, flags)
    rd_chk(12'h032, 8'h20);
    for (int c = 2; c <= 9; c++) begin
      wr(12'h03c, {2'b01, 4'h0, c[4:3]});
      wr(12'h05a, {c[2:0], 5'h00});
      exp_ps = (c >= 3 && c <= 8) ? 9'(175 + 25 * (8 - c)) : 9'h000;
      `CHK("delay on", 1'b1, reference_delay_on)
      `CHK("code", 5'(c), reference_delay_code)
      `CHK("ps", exp_ps, reference_delay_ps)
    end
    rd_chk(12'h03c, 8'h41);
    rd_chk(12'h05a, 8'h20);
    wr(12'h03c, 8'h01);
    `CHK("ps", 9'h000, reference_delay_ps)
    wr(12'h000, 8'h01);
    `CHK("code", 5'h09, reference_delay_code)
    wr(12'h000, 8'h81);
    `CHK("flags", 7'h00, flags)
    `CHK("code", 5'h00, reference_delay_code)
    wr(12'h011, 8'hff);
    wr(12'h012, 8'h04);
    wr(12'h020, 8'h01);
    `CHK("flags", 7'h00, flags)
    rd_chk(12'h011, 8'hff);
    rd_chk(12'h020, 8'h00);
    tally_and_finish();
  end
endmodule : test_master_page_power_sysref_config
